// ==== hdl/ruc_pkg.sv ====
// package: opcodes, table layout and timing constants for the reset, unique-id and parameter-table commands
package ruc_pkg;
  localparam logic [7:0] OP_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC = 8'h99;
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
  localparam logic [7:0] OP_PARAM_TABLE = 8'h5A;
  localparam int UID_DUMMY_BYTES = 4;
  localparam int PT_ADDR_BYTES = 3;
  localparam int PT_DUMMY_BYTES = 1;
  localparam int UID_BITS = 128;
  localparam int TABLE_BYTES = 24;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  localparam logic [7:0] MAKER_ID_DEFAULT = 8'h5C; // arbitrary neutral value
  localparam logic [UID_BITS-1:0] UID_DEFAULT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210; // arbitrary value
  localparam int RECOVERY_NS = 40000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    RUC_OPCODE = 3'b000,
    RUC_ADDR = 3'b001,
    RUC_DUMMY = 3'b011,
    RUC_DATA = 3'b010,
    RUC_IGNORE = 3'b110
  } ruc_phase_t;

  typedef struct packed {
    logic sel_n;
    logic sclk;
    logic sin;
  } ruc_link_in_t;

  typedef struct packed {
    logic sout;
    logic sout_oe;
  } ruc_link_out_t;

  typedef struct packed {
    logic pe_busy;
    logic pe_suspended;
  } ruc_core_stat_t;
endpackage

// ==== hdl/ruc_fifo.sv ====
// file: parameterised valid/ready fifo built from flip-flops
`timescale 1ns/1ps
module ruc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire empty = (wr_reg == rd_reg);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_reg[rd_reg[AW-1:0]];
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) mem_reg[wr_reg[AW-1:0]] <= in_data;
  end
endmodule

// ==== hdl/ruc_cmd.sv ====
// file: serial command interpreter for software reset, unique-id read and parameter-table read
`timescale 1ns/1ps
module ruc_cmd #(
  parameter logic [7:0] MAKER_ID = ruc_pkg::MAKER_ID_DEFAULT, // arbitrary neutral value
  parameter logic [ruc_pkg::UID_BITS-1:0] UNIQUE_ID = ruc_pkg::UID_DEFAULT, // arbitrary value
  parameter int RECOVERY_CYCLES = ruc_pkg::RECOVERY_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire ruc_pkg::ruc_link_in_t link_in,
  output ruc_pkg::ruc_link_out_t link_out,
  input wire ruc_pkg::ruc_core_stat_t core_stat,
  output logic soft_reset,
  output logic pe_abort,
  output logic recovering,
  output logic reset_armed
);
  initial begin
    // the recovery checks look two cycles past the reset pulse
    if (RECOVERY_CYCLES < 2) $error("recovery count must be at least two");
  end

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  // the serial clock is sampled, so it must run well below a quarter of ref_clk
  // select and sclk keep a third stage only to see edges; logic reads stage two
  logic [2:0] sel_sync_reg;
  logic [2:0] sclk_sync_reg;
  logic [1:0] sin_sync_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_sync_reg <= 3'b111;
      sclk_sync_reg <= 3'b000;
      sin_sync_reg <= 2'b00;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], link_in.sel_n};
      sclk_sync_reg <= {sclk_sync_reg[1:0], link_in.sclk};
      sin_sync_reg <= {sin_sync_reg[0], link_in.sin};
    end
  end
  wire sel_n_s = sel_sync_reg[1];
  wire frame_end = sel_sync_reg[1] && !sel_sync_reg[2];
  wire sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2] && !sel_n_s;
  wire sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2] && !sel_n_s;
  wire sin_s = sin_sync_reg[1];

  // ****************************************
  // parameter table
  // ****************************************
  // only the three headers are held; the table body beyond them is not served and reads blank
  function automatic logic [7:0] table_byte(input logic [23:0] addr);
    logic [7:0] b;
    b = ruc_pkg::BLANK_BYTE;
    case (addr)
      24'h00_0000: b = 8'h53;
      24'h00_0001: b = 8'h46;
      24'h00_0002: b = 8'h44;
      24'h00_0003: b = 8'h50;
      24'h00_0004: b = 8'h00;
      24'h00_0005: b = 8'h01;
      24'h00_0006: b = 8'h01;
      24'h00_0008: b = 8'h00;
      24'h00_0009: b = 8'h00;
      24'h00_000A: b = 8'h01;
      24'h00_000B: b = 8'h09;
      24'h00_000C: b = 8'h30;
      24'h00_000D: b = 8'h00;
      24'h00_000E: b = 8'h00;
      24'h00_0010: b = MAKER_ID;
      24'h00_0011: b = 8'h00;
      24'h00_0012: b = 8'h01;
      24'h00_0013: b = 8'h03;
      24'h00_0014: b = 8'h60;
      24'h00_0015: b = 8'h00;
      24'h00_0016: b = 8'h00;
      // 07h, 0Fh, 17h and the body beyond fall to blank, fixed in logic
      default: b = ruc_pkg::BLANK_BYTE;
    endcase
    return b;
  endfunction

  // ****************************************
  // command sequencer
  // ****************************************
  ruc_pkg::ruc_phase_t phase_reg;
  ruc_pkg::ruc_phase_t phase_next;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [3:0] byte_reg;
  logic [7:0] opcode_reg;
  logic [23:0] addr_reg;
  logic arm_reg;
  logic exec_pending_reg;
  logic [$clog2(RECOVERY_CYCLES+1)-1:0] recov_reg;

  wire [7:0] shifted = {shift_reg[6:0], sin_s};
  wire byte_done = sclk_rise && (bit_reg == 3'd7);
  wire is_uid = (shifted == ruc_pkg::OP_UNIQUE_ID);
  wire is_pt = (shifted == ruc_pkg::OP_PARAM_TABLE);
  // suspended core still takes the table read: busy blocks it only when not suspended
  wire pt_ok = is_pt && (!core_stat.pe_busy || core_stat.pe_suspended);
  wire uid_ok = is_uid && !core_stat.pe_busy;
  wire op_done = (phase_reg == ruc_pkg::RUC_OPCODE) && byte_done;
  wire addr_last = (phase_reg == ruc_pkg::RUC_ADDR) && byte_done
    && (byte_reg == 4'(ruc_pkg::PT_ADDR_BYTES - 1));
  wire [3:0] dummy_count = (opcode_reg == ruc_pkg::OP_UNIQUE_ID) ?
    4'(ruc_pkg::UID_DUMMY_BYTES) : 4'(ruc_pkg::PT_DUMMY_BYTES);
  wire dummy_last = (phase_reg == ruc_pkg::RUC_DUMMY) && byte_done && (byte_reg == dummy_count - 4'd1);

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      ruc_pkg::RUC_OPCODE: begin
        if (byte_done) begin
          if (uid_ok) phase_next = ruc_pkg::RUC_DUMMY;
          else if (pt_ok) phase_next = ruc_pkg::RUC_ADDR;
          else phase_next = ruc_pkg::RUC_IGNORE;
        end
      end
      ruc_pkg::RUC_ADDR: if (addr_last) phase_next = ruc_pkg::RUC_DUMMY;
      ruc_pkg::RUC_DUMMY: if (dummy_last) phase_next = ruc_pkg::RUC_DATA;
      ruc_pkg::RUC_DATA: phase_next = ruc_pkg::RUC_DATA;
      ruc_pkg::RUC_IGNORE: phase_next = ruc_pkg::RUC_IGNORE;
      default: phase_next = ruc_pkg::RUC_IGNORE;
    endcase
    // select high always drops back to waiting for an opcode
    if (sel_n_s) phase_next = ruc_pkg::RUC_OPCODE;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= ruc_pkg::RUC_OPCODE;
      shift_reg <= 8'h00;
      bit_reg <= 3'd0;
      byte_reg <= 4'd0;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
    end else begin
      phase_reg <= phase_next;
      if (sel_n_s) begin
        bit_reg <= 3'd0;
        byte_reg <= 4'd0;
      end else if (sclk_rise) begin
        shift_reg <= shifted;
        bit_reg <= bit_reg + 3'd1;
        if (op_done) opcode_reg <= shifted;
        if (phase_reg == ruc_pkg::RUC_ADDR) addr_reg <= {addr_reg[22:0], sin_s};
        // dummy bits are counted but never stored
        if (byte_done) byte_reg <= (op_done || addr_last || dummy_last) ? 4'd0 : byte_reg + 4'd1;
      end
    end
  end

  // ****************************************
  // reset arm / execute
  // ****************************************
  // opcode is only acted on once select rises, so a truncated byte never counts
  // extra clocks after the opcode byte, other than a multiple of 128, make the frame neither a whole arm nor a whole execute
  wire frame_exact = (bit_reg == 3'd0) && (byte_reg == 4'd0);
  // the armed state lives across frames until the next completed opcode
  logic op_frame_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) op_frame_reg <= 1'b0;
    else if (sel_n_s) op_frame_reg <= 1'b0;
    else if (op_done) op_frame_reg <= 1'b1;
  end
  wire frame_single = frame_end && op_frame_reg && frame_exact && (phase_reg == ruc_pkg::RUC_IGNORE);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_reg <= 1'b0;
      exec_pending_reg <= 1'b0;
      recov_reg <= '0;
    end else begin
      exec_pending_reg <= 1'b0;
      if (frame_end && op_frame_reg) begin
        // any completed opcode other than the arm clears the armed state, the no-op included
        arm_reg <= (opcode_reg == ruc_pkg::OP_RESET_ARM) && frame_single;
        if (arm_reg && frame_single && opcode_reg == ruc_pkg::OP_RESET_EXEC) exec_pending_reg <= 1'b1;
      end
      // recovery is only a status for the core; the link itself is not gated during it
      if (exec_pending_reg) recov_reg <= ($bits(recov_reg))'(RECOVERY_CYCLES);
      else if (recov_reg != '0) recov_reg <= recov_reg - 1'b1;
    end
  end
  assign soft_reset = exec_pending_reg;
  assign pe_abort = exec_pending_reg && core_stat.pe_busy;
  assign recovering = (recov_reg != '0);
  assign reset_armed = arm_reg;

  // ****************************************
  // read data path through fifo
  // ****************************************
  logic [23:0] rd_idx_reg;
  // the id is a parameter, so nothing on the link can reach or rewrite it
  wire [7:0] uid_byte = UNIQUE_ID[ruc_pkg::UID_BITS-1 - 8*rd_idx_reg[3:0] -: 8];
  logic fill_reg;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  logic load_byte;
  wire data_phase = (phase_reg == ruc_pkg::RUC_DATA);
  wire is_uid_cmd = (opcode_reg == ruc_pkg::OP_UNIQUE_ID);
  // a uid read stops filling after sixteen bytes and the output then falls undriven
  wire uid_left = !is_uid_cmd || (rd_idx_reg < 24'(ruc_pkg::UID_BITS / 8));
  wire [7:0] fill_byte = is_uid_cmd ? uid_byte : table_byte(rd_idx_reg);
  // flush on select or reset so no stale byte leaks into the next read
  wire flush = sel_n_s || soft_reset;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_idx_reg <= 24'h00_0000;
      fill_reg <= 1'b0;
    end else if (flush) begin
      fill_reg <= 1'b0;
    end else if (dummy_last) begin
      rd_idx_reg <= is_uid_cmd ? 24'h00_0000 : addr_reg;
      fill_reg <= 1'b1;
    end else if (fill_reg && fifo_in_ready && uid_left) begin
      rd_idx_reg <= rd_idx_reg + 24'd1;
    end
  end

  // the fill side runs ahead of sclk, so a byte already waits at every load
  ruc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .flush(flush),
    .in_data(fill_byte),
    .in_valid(fill_reg && uid_left),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(load_byte)
  );

  // ****************************************
  // serial output
  // ****************************************
  logic [7:0] out_sh_reg;
  logic [2:0] out_bit_reg;
  logic out_live_reg;
  logic sout_reg;
  // sout moves only on falling sclk so the host samples a settled bit on the rise
  assign load_byte = data_phase && sclk_fall && (out_bit_reg == 3'd0) && fifo_out_valid;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sh_reg <= 8'h00;
      out_bit_reg <= 3'd0;
      out_live_reg <= 1'b0;
      sout_reg <= 1'b0;
    end else if (!data_phase) begin
      out_bit_reg <= 3'd0;
      out_live_reg <= 1'b0;
    end else if (sclk_fall) begin
      if (load_byte) begin
        sout_reg <= fifo_out_data[7];
        out_sh_reg <= {fifo_out_data[6:0], 1'b0};
        out_bit_reg <= 3'd1;
        out_live_reg <= 1'b1;
      end else if (out_bit_reg != 3'd0) begin
        sout_reg <= out_sh_reg[7];
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        out_bit_reg <= out_bit_reg + 3'd1;
      end else begin
        out_live_reg <= 1'b0;
      end
    end
  end
  assign link_out.sout = sout_reg;
  assign link_out.sout_oe = out_live_reg && data_phase;

  // ****************************************
  // checks
  // ****************************************
  arm_exec_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    soft_reset |-> $past(arm_reg) && !arm_reg) else $error("reset without prior arm");
  arm_whole_frame_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (frame_end && op_frame_reg && !frame_exact) |=> !arm_reg)
    else $error("arm kept after a frame longer than one byte");
  other_cmd_cancel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (frame_end && op_frame_reg && opcode_reg != ruc_pkg::OP_RESET_ARM) |=> !arm_reg)
    else $error("arm survived another command");
  reset_single_pulse_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    soft_reset |=> !soft_reset && !arm_reg) else $error("reset pulse longer than one cycle");
  reset_to_standby_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    soft_reset |=> !fill_reg && !fifo_out_valid && (phase_reg == ruc_pkg::RUC_OPCODE))
    else $error("read state survived the reset");
  abort_on_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (soft_reset && core_stat.pe_busy) |-> pe_abort) else $error("busy core not aborted");
  recovery_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    soft_reset |=> recovering ##1 recovering) else $error("recovery not started");
  recovery_length_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    soft_reset |=> recov_reg == ($bits(recov_reg))'(RECOVERY_CYCLES)) else $error("recovery count wrong");

  // ****************************************
  // checks on the read path
  // ****************************************
  uid_first_byte_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (fill_reg && uid_left && is_uid_cmd && rd_idx_reg == 24'h00_0000)
    |-> fill_byte == UNIQUE_ID[ruc_pkg::UID_BITS-1 -: 8]) else $error("uid does not start at its top byte");
  select_stops_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel_n_s |=> !link_out.sout_oe) else $error("output driven after select high");
  dummy_undriven_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (phase_reg == ruc_pkg::RUC_DUMMY) |-> !out_live_reg && !link_out.sout_oe) else $error("output live in dummy");
  signature_bytes_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (fill_reg && uid_left && !is_uid_cmd && rd_idx_reg == 24'h00_0000) |-> fill_byte == 8'h53)
    else $error("table signature wrong");
  blank_bytes_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (fill_reg && uid_left && !is_uid_cmd && (rd_idx_reg == 24'h00_0007 || rd_idx_reg == 24'h00_000F
    || rd_idx_reg == 24'h00_0017)) |-> fill_byte == ruc_pkg::BLANK_BYTE) else $error("unused byte not blank");

  table_addr_start_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (dummy_last && !is_uid_cmd && !sel_n_s) |=> rd_idx_reg == $past(addr_reg))
    else $error("table read start address wrong");
  suspended_table_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (op_done && is_pt && core_stat.pe_suspended) |=> (phase_reg == ruc_pkg::RUC_ADDR))
    else $error("table read refused while suspended");
endmodule

// ==== verification/ruc_host_model.sv ====
// file: behavioural host serial controller driving the command link in spi mode 0
`timescale 1ns/1ps
module ruc_host_model #(
  parameter int HALF = 8
) (
  input wire logic ref_clk,
  output ruc_pkg::ruc_link_in_t link_in,
  input wire ruc_pkg::ruc_link_out_t link_out
);
  logic last_sin;
  logic dummy_oe;
  logic data_oe;
  logic [7:0] rx_q[$];

  initial begin
    link_in = 3'b100;
    last_sin = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // sclk stands low outside frames; HALF keeps sclk well under ref_clk/8
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx, output logic oe_all, output logic oe_any);
    oe_all = 1'b1;
    oe_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link_in.sin = tx[i];
      last_sin = tx[i];
      wait_clk(HALF);
      link_in.sclk = 1'b1;
      rx[i] = link_out.sout;
      oe_all = oe_all & link_out.sout_oe;
      oe_any = oe_any | link_out.sout_oe;
      wait_clk(HALF);
      link_in.sclk = 1'b0;
    end
  endtask

  // ***********************************************
  // whole command frame
  // ***********************************************
  task automatic run_cmd(input logic [7:0] op, input int n_addr, input logic [23:0] addr, input int n_dummy,
                         input int n_data);
    logic [7:0] rx;
    logic oa;
    logic on;
    rx_q.delete();
    dummy_oe = 1'b0;
    data_oe = 1'b1;
    wait_clk(1);
    link_in.sel_n = 1'b0;
    wait_clk(HALF);
    xfer_byte(op, rx, oa, on);
    for (int i = n_addr - 1; i >= 0; i--) begin
      xfer_byte(addr[8*i +: 8], rx, oa, on);
    end
    for (int i = 0; i < n_dummy; i++) begin
      xfer_byte(8'hA5, rx, oa, on);
      dummy_oe = dummy_oe | on;
    end
    for (int i = 0; i < n_data; i++) begin
      xfer_byte(8'h3C, rx, oa, on);
      rx_q.push_back(rx);
      data_oe = data_oe & oa;
    end
    wait_clk(HALF);
    link_in.sel_n = 1'b1;
    link_in.sin = ~last_sin;
    wait_clk(HALF);
  endtask
endmodule

// ==== verification/testbench.sv ====
// file: self-checking testbench for the reset, unique-id and parameter-table command interpreter
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] MAKER = 8'h3A; // arbitrary neutral value
  localparam logic [127:0] UID = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0; // arbitrary value
  localparam int REC = 4;
  localparam int LIMIT = 40000;
  logic ref_clk;
  logic arst_n;
  ruc_pkg::ruc_link_in_t link_in;
  ruc_pkg::ruc_link_out_t link_out;
  ruc_pkg::ruc_core_stat_t core_stat;
  logic soft_reset;
  logic pe_abort;
  logic recovering;
  logic reset_armed;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_reset = 0;
  int n_abort = 0;
  int n_recov = 0;
  logic [7:0] tbl [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09,
                             8'h30, 8'h00, 8'h00, 8'hFF, MAKER, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};

  ruc_cmd #(.MAKER_ID(MAKER), .UNIQUE_ID(UID), .RECOVERY_CYCLES(REC), .FIFO_DEPTH(16)) u_ruc_cmd (
    .ref_clk(ref_clk), .arst_n(arst_n), .link_in(link_in), .link_out(link_out), .core_stat(core_stat),
    .soft_reset(soft_reset), .pe_abort(pe_abort), .recovering(recovering), .reset_armed(reset_armed));
  ruc_host_model #(.HALF(8)) u_ruc_host_model (.ref_clk(ref_clk), .link_in(link_in), .link_out(link_out));

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // pulses are counted so a missing or doubled pulse shows up in the totals
  always @(posedge ref_clk) begin
    cycles++;
    if (soft_reset === 1'b1) n_reset++;
    if (pe_abort === 1'b1) n_abort++;
    if (recovering === 1'b1) n_recov++;
    if (cycles == LIMIT) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic set_core(input logic busy, input logic susp);
    @(negedge ref_clk);
    core_stat = {busy, susp};
  endtask

  task automatic table_full();
    u_ruc_host_model.run_cmd(ruc_pkg::OP_PARAM_TABLE, 3, 24'h00_0000, 1, 24);
    for (int i = 0; i < 24; i++) begin
      check(128'(u_ruc_host_model.rx_q[i]), 128'(tbl[i]), "table byte");
    end
    check(128'(u_ruc_host_model.dummy_oe), 128'(1'b0), "oe in dummy");
    check(128'(u_ruc_host_model.data_oe), 128'(1'b1), "oe in data");
  endtask

  task automatic table_partial();
    u_ruc_host_model.run_cmd(ruc_pkg::OP_PARAM_TABLE, 3, 24'h00_000E, 1, 3);
    for (int i = 0; i < 3; i++) begin
      check(128'(u_ruc_host_model.rx_q[i]), 128'(tbl[14+i]), "offset byte");
    end
    check(128'(link_out.sout_oe), 128'(1'b0), "oe after select");
  endtask

  task automatic uid_read();
    u_ruc_host_model.run_cmd(ruc_pkg::OP_UNIQUE_ID, 0, 24'h00_0000, 4, 16);
    for (int i = 0; i < 16; i++) begin
      check(128'(u_ruc_host_model.rx_q[i]), 128'(UID[127-8*i -: 8]), "uid byte");
    end
    check(128'(u_ruc_host_model.dummy_oe), 128'(1'b0), "uid dummy oe");
  endtask

  task automatic busy_reads();
    set_core(1'b1, 1'b1);
    u_ruc_host_model.run_cmd(ruc_pkg::OP_PARAM_TABLE, 3, 24'h00_0000, 1, 4);
    for (int i = 0; i < 4; i++) begin
      check(128'(u_ruc_host_model.rx_q[i]), 128'(tbl[i]), "suspended read");
    end
    set_core(1'b1, 1'b0);
    u_ruc_host_model.run_cmd(ruc_pkg::OP_PARAM_TABLE, 3, 24'h00_0000, 1, 1);
    check(128'(u_ruc_host_model.data_oe), 128'(1'b0), "busy table refused");
    u_ruc_host_model.run_cmd(ruc_pkg::OP_UNIQUE_ID, 0, 24'h00_0000, 4, 1);
    check(128'(u_ruc_host_model.data_oe), 128'(1'b0), "busy uid refused");
    set_core(1'b0, 1'b0);
  endtask

  task automatic reset_seq(input logic busy);
    int r0;
    int a0;
    int v0;
    set_core(busy, 1'b0);
    r0 = n_reset;
    a0 = n_abort;
    v0 = n_recov;
    u_ruc_host_model.run_cmd(ruc_pkg::OP_RESET_ARM, 0, 24'h00_0000, 0, 0);
    check(128'(reset_armed), 128'(1'b1), "armed");
    u_ruc_host_model.run_cmd(ruc_pkg::OP_RESET_EXEC, 0, 24'h00_0000, 0, 0);
    u_ruc_host_model.wait_clk(REC + 2);
    check(128'(n_reset - r0), 128'(1), "reset pulses");
    check(128'(n_abort - a0), 128'(busy), "abort pulses");
    check(128'(n_recov - v0), 128'(REC), "recovery length");
    check(128'(reset_armed), 128'(1'b0), "armed after reset");
    set_core(1'b0, 1'b0);
  endtask

  task automatic reset_cancel(input logic [7:0] op);
    int r0;
    r0 = n_reset;
    u_ruc_host_model.run_cmd(ruc_pkg::OP_RESET_ARM, 0, 24'h00_0000, 0, 0);
    u_ruc_host_model.run_cmd(op, 3, 24'h00_0000, 1, 1);
    check(128'(reset_armed), 128'(1'b0), "disarmed");
    u_ruc_host_model.run_cmd(ruc_pkg::OP_RESET_EXEC, 0, 24'h00_0000, 0, 0);
    u_ruc_host_model.wait_clk(REC + 2);
    check(128'(n_reset - r0), 128'(0), "no reset");
  endtask

  task automatic reset_long();
    int r0;
    r0 = n_reset;
    u_ruc_host_model.run_cmd(ruc_pkg::OP_RESET_ARM, 1, 24'h00_0000, 0, 0);
    check(128'(reset_armed), 128'(1'b0), "arm frame too long");
    u_ruc_host_model.run_cmd(ruc_pkg::OP_RESET_EXEC, 0, 24'h00_0000, 0, 0);
    u_ruc_host_model.wait_clk(REC + 2);
    check(128'(n_reset - r0), 128'(0), "reset after long arm");
  endtask

  initial begin
    arst_n = 1'b0;
    core_stat = 2'b00;
    repeat (20) @(negedge ref_clk);
    check(128'({reset_armed, recovering, link_out.sout_oe}), 128'(3'b000), "reset values");
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    table_full();
    table_partial();
    uid_read();
    busy_reads();
    reset_seq(1'b0);
    reset_seq(1'b1);
    reset_cancel(ruc_pkg::OP_NO_OPERATION);
    reset_cancel(ruc_pkg::OP_PARAM_TABLE);
    reset_long();
    uid_read();
    report_and_stop();
  end
endmodule
